// file: common/ptb_pkg.sv
package ptb_pkg;

    localparam int DATA_W     = 32;
    localparam int FIFO_DEPTH = 16;
    localparam int BASE_W     = 8;
    localparam int BASE_LSB   = 24;
    localparam int MEM_EN_POS = 1;

    // configuration header byte offsets
    localparam logic [7:0] CFG_CMD_OFS = 8'h04;
    localparam logic [7:0] CFG_BAR_OFS = 8'h10;

    localparam logic [BASE_W-1:0] BASE_RST   = 8'h00;
    localparam logic              MEM_EN_RST = 1'b0;
    localparam logic [1:0]        CFG_TYPE0  = 2'h0;
    localparam logic [DATA_W-1:0] ZERO_WORD  = 32'h0000_0000;

    // command codes as seen on the c/be pins
    localparam logic [3:0] CMD_MEM_RD      = 4'h6;
    localparam logic [3:0] CMD_MEM_WR      = 4'h7;
    localparam logic [3:0] CMD_CFG_RD      = 4'hA;
    localparam logic [3:0] CMD_CFG_WR      = 4'hB;
    localparam logic [3:0] CMD_MEM_RD_MUL  = 4'hC;
    localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE;
    localparam logic [3:0] CMD_MEM_WR_INV  = 4'hF;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_DATA      = 3'b001,
        ST_BUSY      = 3'b010,
        ST_RELEASE   = 3'b011,
        ST_STOP_WAIT = 3'b100
    } ptb_state_e;

    typedef struct packed {
        logic [DATA_W-1:0] ad;
        logic [3:0]        cbe_n;
        logic              frame_n;
        logic              irdy_n;
        logic              idsel;
    } ptb_bus_in_s;

    typedef struct packed {
        logic [DATA_W-1:0] ad;
        logic              ad_oe_n;
        logic              trdy_n;
        logic              stop_n;
        logic              devsel_n;
        logic              ctl_oe_n;
    } ptb_tgt_out_s;

    typedef struct packed {
        logic [DATA_W-1:0] rd_data;
        logic              dev_req_n;
        logic              abort_n;
        logic              retry_n;
    } ptb_be_in_s;

endpackage : ptb_pkg

// file: src/ptb_fifo.sv
`timescale 1ns/1ns
module ptb_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 16
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] wp_nxt;
    logic [AW-1:0] rp_r;
    logic [AW-1:0] rp_nxt;
    logic [AW:0]   cnt_r;
    logic [AW:0]   cnt_nxt;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wp_nxt  = push ? wp_r + 1'b1 : wp_r;
        rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

endmodule : ptb_fifo

// file: src/ptb_addr_dec.sv
`timescale 1ns/1ns
module ptb_addr_dec (
    input  wire logic [31:0] ad,
    input  wire logic [3:0]  cbe_n,
    input  wire logic        idsel,
    input  wire logic [7:0]  base,
    input  wire logic        mem_en,
    output logic             mem_hit,
    output logic             cfg_hit,
    output logic             is_write
);
    logic is_mem;
    logic match;

    always_comb begin
        is_mem = (cbe_n == ptb_pkg::CMD_MEM_RD) || (cbe_n == ptb_pkg::CMD_MEM_WR)
              || (cbe_n == ptb_pkg::CMD_MEM_RD_MUL) || (cbe_n == ptb_pkg::CMD_MEM_RD_LINE)
              || (cbe_n == ptb_pkg::CMD_MEM_WR_INV);
        match    = (ad[31:ptb_pkg::BASE_LSB] == base); // R16
        mem_hit  = is_mem && match && mem_en; // R16 R21
        cfg_hit  = idsel && (ad[1:0] == ptb_pkg::CFG_TYPE0)
                && ((cbe_n == ptb_pkg::CMD_CFG_RD) || (cbe_n == ptb_pkg::CMD_CFG_WR));
        is_write = (cbe_n == ptb_pkg::CMD_MEM_WR) || (cbe_n == ptb_pkg::CMD_MEM_WR_INV)
                || (cbe_n == ptb_pkg::CMD_CFG_WR);
    end

endmodule : ptb_addr_dec

// file: src/ptb_target.sv
`timescale 1ns/1ns
// Operation
// R1: on a hit, present the address word and raise hit, space select, write flag.
// R2: back end asserts done request low and holds it until acknowledge goes high.
// R3: acknowledge goes high when irdy and trdy meet with frame deasserted.
// R4: back-end abort or retry inputs end the cycle with matching bus terminations.
// R5: back end reads its program from write data: low 24 bits, command bits 27:24.
// R6: all target options are supported except exclusive locking.
// R7: sequencer resets to idle and watches the bus for a new access.
// R8: address phase compares base; match raises hit and enters data, else busy.
// R9: busy waits until the foreign transaction ends and the bus is idle.
// R10: data ends in release for single phases, in stop wait on burst attempts.
// R11: release state frees drivers and returns to idle on the next clock.
// R12: stop wait holds stop until frame deasserts, then goes to release.
// R13: disconnect drives stop, trdy and devsel together.
// R14: initiator drops frame after a disconnect and completes only with irdy.
// R15: no read data or full fifo ends the cycle by retry: stop, devsel, no trdy.
// R16: upper address byte compared with base, qualified by memory enable.
// R17: unimplemented configuration registers ignore writes and read zero.
// R18: base register reads zero in its don't-care bits for sizing.
// R19: base byte sits at header offset 10h and loads on configuration write.
// R20: initiator drives the two low address lines as 00 in configuration cycles.
// R21: memory enable zero leaves only configuration; one allows memory space.
// R22: bus data drivers enabled on reads, back-end drivers on writes.
// R23: a word moves only on an edge with irdy and trdy both asserted.
// R24: only upper 8 base bits are writable, lower 24 read zero.
// R25: reset clears state, base byte, memory enable, hit and acknowledge.
module ptb_target (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire ptb_pkg::ptb_bus_in_s bus,
    output ptb_pkg::ptb_tgt_out_s     tgt,
    input  wire ptb_pkg::ptb_be_in_s  be_in,
    output logic [31:0]               be_addr,
    output logic                      hit,
    output logic                      space_sel,
    output logic                      mem_wr,
    output logic                      dev_ack_n,
    output logic [31:0]               be_wr_data,
    output logic                      be_wr_valid,
    input  wire logic                 be_wr_ready,
    output logic                      be_d_oe_n
);
    ptb_pkg::ptb_state_e state_r;
    ptb_pkg::ptb_state_e state_nxt;
    logic        devsel_r;
    logic        devsel_nxt;
    logic        trdy_r;
    logic        trdy_nxt;
    logic        stop_r;
    logic        stop_nxt;
    logic [31:0] ad_out_r;
    logic [31:0] ad_out_nxt;
    logic        hit_r;
    logic        hit_nxt;
    logic        space_r;
    logic        space_nxt;
    logic        ack_r;
    logic        ack_nxt;
    logic [31:0] be_addr_r;
    logic [31:0] be_addr_nxt;
    logic        cur_wr_r;
    logic        cur_wr_nxt;
    logic        cfg_r;
    logic        cfg_nxt;
    logic [7:0]  cfg_ofs_r;
    logic [7:0]  cfg_ofs_nxt;
    logic [7:0]  base_r;
    logic [7:0]  base_nxt;
    logic        mem_en_r;
    logic        mem_en_nxt;

    logic        mem_hit;
    logic        cfg_hit;
    logic        is_write;
    logic        xfer;
    logic        fifo_in_ready;
    logic [31:0] cfg_rd_val;
    logic        rd_ready;
    logic        term_retry;
    logic        term_abort;

    ptb_addr_dec u_dec (
        .ad       (bus.ad),
        .cbe_n    (bus.cbe_n),
        .idsel    (bus.idsel),
        .base     (base_r),
        .mem_en   (mem_en_r),
        .mem_hit  (mem_hit),
        .cfg_hit  (cfg_hit),
        .is_write (is_write)
    );

    ptb_fifo #(
        .W     (ptb_pkg::DATA_W),
        .DEPTH (ptb_pkg::FIFO_DEPTH)
    ) u_wr_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (xfer && cur_wr_r && !cfg_r),
        .in_ready  (fifo_in_ready),
        .in_data   (bus.ad),
        .out_valid (be_wr_valid),
        .out_ready (be_wr_ready),
        .out_data  (be_wr_data)
    );

    assign xfer = (state_r == ptb_pkg::ST_DATA) && trdy_r && !bus.irdy_n; // R23

    always_comb begin
        cfg_rd_val = ptb_pkg::ZERO_WORD; // R17
        if (cfg_ofs_r == ptb_pkg::CFG_BAR_OFS) begin
            cfg_rd_val[31:ptb_pkg::BASE_LSB] = base_r; // R18 R24
        end else if (cfg_ofs_r == ptb_pkg::CFG_CMD_OFS) begin
            cfg_rd_val[ptb_pkg::MEM_EN_POS] = mem_en_r;
        end
    end

    always_comb begin
        rd_ready   = cfg_r || !be_in.dev_req_n;
        term_abort = !cfg_r && !be_in.abort_n; // R4
        term_retry = !cfg_r && (!be_in.retry_n
                  || (cur_wr_r ? !fifo_in_ready : !rd_ready)); // R4 R15
    end

    // sequencer, no lock handling by design R6
    always_comb begin
        state_nxt   = state_r;
        devsel_nxt  = devsel_r;
        trdy_nxt    = trdy_r;
        stop_nxt    = stop_r;
        ad_out_nxt  = ad_out_r;
        hit_nxt     = hit_r;
        space_nxt   = space_r;
        ack_nxt     = ack_r;
        be_addr_nxt = be_addr_r;
        cur_wr_nxt  = cur_wr_r;
        cfg_nxt     = cfg_r;
        cfg_ofs_nxt = cfg_ofs_r;
        base_nxt    = base_r;
        mem_en_nxt  = mem_en_r;
        case (state_r)
            ptb_pkg::ST_IDLE: begin
                if (!bus.frame_n) begin // R7
                    cur_wr_nxt  = is_write;
                    cfg_ofs_nxt = bus.ad[7:0];
                    if (mem_hit) begin // R8
                        state_nxt   = ptb_pkg::ST_DATA;
                        devsel_nxt  = 1'b1;
                        hit_nxt     = 1'b1; // R1
                        space_nxt   = 1'b1;
                        ack_nxt     = 1'b1;
                        be_addr_nxt = bus.ad; // R1
                        cfg_nxt     = 1'b0;
                    end else if (cfg_hit) begin
                        state_nxt  = ptb_pkg::ST_DATA;
                        devsel_nxt = 1'b1;
                        cfg_nxt    = 1'b1;
                    end else begin
                        state_nxt = ptb_pkg::ST_BUSY; // R8
                    end
                end
            end
            ptb_pkg::ST_DATA: begin
                if (xfer) begin
                    trdy_nxt = 1'b0;
                    if (cfg_r && cur_wr_r) begin
                        if (cfg_ofs_r == ptb_pkg::CFG_BAR_OFS) begin
                            base_nxt = bus.ad[31:ptb_pkg::BASE_LSB]; // R19 R24
                        end else if (cfg_ofs_r == ptb_pkg::CFG_CMD_OFS) begin
                            mem_en_nxt = bus.ad[ptb_pkg::MEM_EN_POS]; // R21
                        end
                    end
                    if (bus.frame_n) begin
                        state_nxt  = ptb_pkg::ST_RELEASE; // R10
                        devsel_nxt = 1'b0;
                        stop_nxt   = 1'b0;
                        ack_nxt    = 1'b0; // R3
                        hit_nxt    = 1'b0;
                    end else begin
                        state_nxt = ptb_pkg::ST_STOP_WAIT; // R10
                        stop_nxt  = 1'b1;
                    end
                end else if (!trdy_r) begin
                    if (term_abort) begin
                        state_nxt  = ptb_pkg::ST_STOP_WAIT;
                        stop_nxt   = 1'b1;
                        devsel_nxt = 1'b0; // R4
                    end else if (term_retry) begin
                        state_nxt = ptb_pkg::ST_STOP_WAIT; // R15
                        stop_nxt  = 1'b1;
                    end else begin
                        trdy_nxt   = 1'b1;
                        stop_nxt   = !bus.frame_n; // R13
                        ad_out_nxt = cfg_r ? cfg_rd_val : be_in.rd_data;
                    end
                end
            end
            ptb_pkg::ST_STOP_WAIT: begin
                if (bus.frame_n) begin // R12 R14
                    state_nxt  = ptb_pkg::ST_RELEASE;
                    stop_nxt   = 1'b0;
                    devsel_nxt = 1'b0;
                    trdy_nxt   = 1'b0;
                    ack_nxt    = 1'b0;
                    hit_nxt    = 1'b0;
                end
            end
            ptb_pkg::ST_RELEASE: begin
                state_nxt = ptb_pkg::ST_IDLE; // R11
                space_nxt = 1'b0;
            end
            ptb_pkg::ST_BUSY: begin
                if (bus.frame_n && bus.irdy_n) begin
                    state_nxt = ptb_pkg::ST_IDLE; // R9
                end
            end
            default: begin
                state_nxt = ptb_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin // R25
            state_r   <= ptb_pkg::ST_IDLE;
            devsel_r  <= 1'b0;
            trdy_r    <= 1'b0;
            stop_r    <= 1'b0;
            ad_out_r  <= ptb_pkg::ZERO_WORD;
            hit_r     <= 1'b0;
            space_r   <= 1'b0;
            ack_r     <= 1'b0;
            be_addr_r <= ptb_pkg::ZERO_WORD;
            cur_wr_r  <= 1'b0;
            cfg_r     <= 1'b0;
            cfg_ofs_r <= 8'h00;
            base_r    <= ptb_pkg::BASE_RST;
            mem_en_r  <= ptb_pkg::MEM_EN_RST;
        end else begin
            state_r   <= state_nxt;
            devsel_r  <= devsel_nxt;
            trdy_r    <= trdy_nxt;
            stop_r    <= stop_nxt;
            ad_out_r  <= ad_out_nxt;
            hit_r     <= hit_nxt;
            space_r   <= space_nxt;
            ack_r     <= ack_nxt;
            be_addr_r <= be_addr_nxt;
            cur_wr_r  <= cur_wr_nxt;
            cfg_r     <= cfg_nxt;
            cfg_ofs_r <= cfg_ofs_nxt;
            base_r    <= base_nxt;
            mem_en_r  <= mem_en_nxt;
        end
    end

    always_comb begin
        tgt.ad       = ad_out_r;
        tgt.ad_oe_n  = !((state_r == ptb_pkg::ST_DATA) && !cur_wr_r && trdy_r); // R22
        tgt.trdy_n   = !trdy_r;
        tgt.stop_n   = !stop_r;
        tgt.devsel_n = !devsel_r;
        tgt.ctl_oe_n = !((state_r == ptb_pkg::ST_DATA) || (state_r == ptb_pkg::ST_STOP_WAIT)
                     || (state_r == ptb_pkg::ST_RELEASE)); // R11
        be_addr      = be_addr_r;
        hit          = hit_r;
        space_sel    = space_r;
        mem_wr       = hit_r && cur_wr_r;
        dev_ack_n    = !ack_r;
        be_d_oe_n    = !(hit_r && cur_wr_r); // R22
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_release_to_idle: assert property ( // R11
        state_r == ptb_pkg::ST_RELEASE |=> state_r == ptb_pkg::ST_IDLE)
        else $error("release state did not return to idle");

    a_busy_holds: assert property ( // R9
        (state_r == ptb_pkg::ST_BUSY) && !(bus.frame_n && bus.irdy_n)
        |=> state_r == ptb_pkg::ST_BUSY)
        else $error("busy left before bus idle");

    a_stop_wait_exit: assert property ( // R12
        (state_r == ptb_pkg::ST_STOP_WAIT) && bus.frame_n
        |=> (state_r == ptb_pkg::ST_RELEASE) && !stop_r)
        else $error("stop wait did not move to release on frame high");

    a_stop_wait_hold: assert property ( // R12
        (state_r == ptb_pkg::ST_STOP_WAIT) && !bus.frame_n |=> stop_r && $stable(state_r))
        else $error("stop dropped before frame deasserted");

    a_disconnect_trio: assert property ( // R13
        trdy_r && stop_r |-> devsel_r && !tgt.trdy_n && !tgt.stop_n && !tgt.devsel_n)
        else $error("disconnect without all three signals");

    a_retry_shape: assert property ( // R15
        (state_r == ptb_pkg::ST_DATA) && !trdy_r && !cfg_r && cur_wr_r && !fifo_in_ready
        && be_in.abort_n |=> stop_r && devsel_r && !trdy_r)
        else $error("full fifo did not give retry");

    a_ack_release: assert property ( // R3
        xfer && bus.frame_n |=> dev_ack_n && !hit)
        else $error("acknowledge not released at completion");

    a_hit_enter: assert property ( // R8
        (state_r == ptb_pkg::ST_IDLE) && !bus.frame_n && mem_hit
        |=> hit && !dev_ack_n && (state_r == ptb_pkg::ST_DATA) && (be_addr == $past(bus.ad)))
        else $error("hit not raised on address match");

    a_miss_busy: assert property ( // R8
        (state_r == ptb_pkg::ST_IDLE) && !bus.frame_n && !mem_hit && !cfg_hit
        |=> state_r == ptb_pkg::ST_BUSY)
        else $error("miss did not enter busy");

    a_mem_en_gate: assert property ( // R21
        !mem_en_r |-> !mem_hit)
        else $error("memory hit while memory disabled");

    a_bar_load: assert property ( // R19
        xfer && cfg_r && cur_wr_r && (cfg_ofs_r == ptb_pkg::CFG_BAR_OFS)
        |=> base_r == $past(bus.ad[31:ptb_pkg::BASE_LSB]))
        else $error("base byte not loaded");

    a_read_dir: assert property ( // R22
        !tgt.ad_oe_n |-> !cur_wr_r && be_d_oe_n)
        else $error("bus driven on a write cycle");

endmodule : ptb_target

// file: verif/ptb_backend_model.sv
`timescale 1ns/1ns
module ptb_backend_model #(
    parameter logic [31:0] RD_PAT = 32'hC3A5_0F96
) (
    input  wire logic           clk,
    input  wire logic           sys_rst,
    input  wire logic           dev_ack_n,
    input  wire logic           wr_valid,
    input  wire logic [31:0]    wr_data,
    input  wire logic           avail,
    input  wire logic           stall,
    input  wire logic           abrt,
    input  wire logic           rtry,
    output ptb_pkg::ptb_be_in_s be_in,
    output logic                wr_ready,
    output logic [7:0]          wr_cnt,
    output logic [3:0]          cmd_code,
    output logic [23:0]         start_cnt
);
    logic [31:0] log_q [0:31];
    logic [31:0] last_r;
    logic [31:0] junk_r;

    // done request held only while acknowledge stays low
    assign be_in.dev_req_n = !(avail && !dev_ack_n);
    // data lines alternate between 1 and all ones when not offering data
    assign be_in.rd_data   = be_in.dev_req_n ? junk_r : RD_PAT;
    assign be_in.abort_n   = !abrt;
    assign be_in.retry_n   = !rtry;
    assign wr_ready        = !stall;
    // program fields of the newest write word
    assign cmd_code        = last_r[27:24];
    assign start_cnt       = last_r[23:0];

    always_ff @(posedge clk) begin
        junk_r <= ~junk_r + 32'h0000_0001;
        if (sys_rst) begin
            junk_r <= 32'h0000_0001;
            wr_cnt <= 8'h00;
            last_r <= 32'h0000_0000;
        end else if (wr_valid && wr_ready) begin
            log_q[wr_cnt[4:0]] <= wr_data;
            last_r             <= wr_data;
            wr_cnt             <= wr_cnt + 8'h01;
        end
    end
endmodule : ptb_backend_model

// file: verif/pci_target_backend_interface_tb_top.sv
`timescale 1ns/1ns
module pci_target_backend_interface_tb_top;
    localparam logic [31:0] PAT = 32'hC3A5_0F96;
    localparam logic [31:0] BA  = 32'h5A00_0000;
    localparam logic [3:0]  CR  = ptb_pkg::CMD_CFG_RD;
    localparam logic [3:0]  CW  = ptb_pkg::CMD_CFG_WR;
    localparam logic [3:0]  MR  = ptb_pkg::CMD_MEM_RD;
    localparam logic [3:0]  MW  = ptb_pkg::CMD_MEM_WR;
    logic                  clk, sys_rst;
    ptb_pkg::ptb_bus_in_s  b;
    ptb_pkg::ptb_tgt_out_s tgt;
    ptb_pkg::ptb_be_in_s   be;
    logic [31:0]           be_addr, be_wr_data, s_addr, rd;
    logic                  hit, space_sel, mem_wr, dev_ack_n, be_wr_valid, be_wr_ready;
    logic                  be_d_oe_n, avail, stall, abrt, rtry;
    logic                  s_hit, s_sel, s_wr, s_ack, s_doe, s_aoe;
    logic [7:0]            wr_cnt, n0;
    logic [3:0]            cmd_code;
    logic [23:0]           start_cnt;
    logic [3:0]            cmds [0:4];
    int                    kinds [0:4];
    int                    error_cnt, check_count, i;

    ptb_target dut (.clk(clk), .sys_rst(sys_rst), .bus(b), .tgt(tgt), .be_in(be),
        .be_addr(be_addr), .hit(hit), .space_sel(space_sel), .mem_wr(mem_wr),
        .dev_ack_n(dev_ack_n), .be_wr_data(be_wr_data), .be_wr_valid(be_wr_valid),
        .be_wr_ready(be_wr_ready), .be_d_oe_n(be_d_oe_n));
    ptb_backend_model #(.RD_PAT(PAT)) pm (.clk(clk), .sys_rst(sys_rst),
        .dev_ack_n(dev_ack_n), .wr_valid(be_wr_valid), .wr_data(be_wr_data),
        .avail(avail), .stall(stall), .abrt(abrt), .rtry(rtry), .be_in(be),
        .wr_ready(be_wr_ready), .wr_cnt(wr_cnt), .cmd_code(cmd_code),
        .start_cnt(start_cnt));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic wrap_up();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk

    // one transaction; kind 0 data, 1 retry, 2 abort, 3 unclaimed, 4 disconnect
    task automatic cyc(input logic [3:0] c, input logic [31:0] a, input logic [31:0] w,
                       input logic brst, input logic ids, input int ek);
        int n;
        int kk;
        kk = 3;
        b.ad = a;
        b.cbe_n = c;
        b.idsel = ids;
        b.frame_n = 1'b0;
        tick();
        b.ad = w;
        b.cbe_n = 4'h0;
        b.idsel = 1'b0;
        b.frame_n = !brst;
        b.irdy_n = 1'b0;
        s_hit = hit;
        s_sel = space_sel;
        s_wr = mem_wr;
        s_ack = dev_ack_n;
        s_doe = be_d_oe_n;
        s_addr = be_addr;
        for (n = 0; n < 8 && kk == 3; n++) begin
            if (tgt.trdy_n === 1'b0) begin
                kk = (tgt.stop_n === 1'b0) ? 4 : 0;
                rd = tgt.ad;
                s_aoe = tgt.ad_oe_n;
            end else if (tgt.stop_n === 1'b0) begin
                kk = (tgt.devsel_n === 1'b0) ? 1 : 2;
            end
            tick();
        end
        b.frame_n = 1'b1;
        b.irdy_n = 1'b1;
        repeat (3) tick();
        chk(kk, ek);
        if (kk == 3 && ek != 3) begin
            wrap_up();
        end
    endtask : cyc

    initial begin
        error_cnt = 0;
        check_count = 0;
        b = '0;
        b.frame_n = 1'b1;
        b.irdy_n = 1'b1;
        avail = 1'b1;
        stall = 1'b0;
        abrt = 1'b0;
        rtry = 1'b0;
        sys_rst = 1'b1;
        cmds = '{ptb_pkg::CMD_MEM_RD_MUL, ptb_pkg::CMD_MEM_RD_LINE,
                 ptb_pkg::CMD_MEM_WR_INV, 4'h2, 4'h3};
        kinds = '{0, 0, 0, 3, 3};
        repeat (8) tick();
        sys_rst = 1'b0;
        cyc(CR, 32'h0000_0010, 32'h0, 1'b0, 1'b1, 0);
        chk(rd, 32'h0);
        cyc(MW, 32'h0000_0100, 32'h1, 1'b0, 1'b0, 3);
        cyc(CW, 32'h0000_0010, 32'hFFFF_FFFF, 1'b0, 1'b1, 0);
        cyc(CR, 32'h0000_0010, 32'h0, 1'b0, 1'b1, 0);
        chk(rd, 32'hFF00_0000);
        cyc(CW, 32'h0000_0010, 32'h1200_0000, 1'b0, 1'b0, 3);
        cyc(CW, 32'h0000_0010, BA, 1'b0, 1'b1, 0);
        cyc(CR, 32'h0000_0010, 32'h0, 1'b0, 1'b1, 0);
        chk(rd, BA);
        for (i = 0; i < 3; i++) begin
            cyc(CW, 32'h0000_0008 + 32'(i * 16), 32'hFFFF_FFFF, 1'b0, 1'b1, 0);
            cyc(CR, 32'h0000_0008 + 32'(i * 16), 32'h0, 1'b0, 1'b1, 0);
            chk(rd, 32'h0);
        end
        cyc(CW, 32'h0000_0004, 32'h0000_0002, 1'b0, 1'b1, 0);
        cyc(CR, 32'h0000_0004, 32'h0, 1'b0, 1'b1, 0);
        chk(rd, 32'h0000_0002);
        cyc(MW, BA | 32'h1234, 32'h0712_3456, 1'b0, 1'b0, 0);
        chk({s_hit, s_sel, s_wr, s_ack, s_doe}, 5'h1C);
        chk(s_addr, BA | 32'h1234);
        chk({hit, dev_ack_n}, 2'h1);
        chk(cmd_code, 4'h7);
        chk(start_cnt, 24'h12_3456);
        cyc(MW, 32'h5B00_0000, 32'h1, 1'b0, 1'b0, 3);
        cyc(MR, BA, 32'hFFFF_FFFF, 1'b0, 1'b0, 0);
        chk(rd, PAT);
        chk({s_aoe, s_wr, s_doe}, 3'h1);
        avail = 1'b0;
        cyc(MR, BA, 32'hFFFF_FFFF, 1'b0, 1'b0, 1);
        cyc(MR, BA, 32'hFFFF_FFFF, 1'b1, 1'b0, 1);
        avail = 1'b1;
        abrt = 1'b1;
        cyc(MR, BA, 32'hFFFF_FFFF, 1'b0, 1'b0, 2);
        abrt = 1'b0;
        rtry = 1'b1;
        cyc(MW, BA, 32'h2, 1'b0, 1'b0, 1);
        rtry = 1'b0;
        cyc(MW, BA, 32'hB0B0_0001, 1'b1, 1'b0, 4);
        for (i = 0; i < 5; i++) begin
            cyc(cmds[i], BA, 32'h3, 1'b0, 1'b0, kinds[i]);
        end
        n0 = wr_cnt;
        stall = 1'b1;
        for (i = 0; i < 16; i++) begin
            cyc(MW, BA, 32'(i), 1'b0, 1'b0, 0);
        end
        cyc(MW, BA, 32'h99, 1'b0, 1'b0, 1);
        stall = 1'b0;
        for (i = 0; i < 40 && wr_cnt !== n0 + 8'h10; i++) begin
            tick();
        end
        chk(wr_cnt, n0 + 8'h10);
        if (wr_cnt !== n0 + 8'h10) begin
            wrap_up();
        end
        for (i = 0; i < 16; i++) begin
            chk(pm.log_q[n0[4:0] + 5'(i)], 32'(i));
        end
        chk(be_wr_valid, 1'b0);
        sys_rst = 1'b1;
        repeat (2) tick();
        sys_rst = 1'b0;
        tick();
        chk({hit, dev_ack_n, tgt.ctl_oe_n}, 3'h3);
        cyc(MW, BA, 32'h4, 1'b0, 1'b0, 3);
        cyc(CR, 32'h0000_0010, 32'h0, 1'b0, 1'b1, 0);
        chk(rd, 32'h0);
        wrap_up();
    end
endmodule : pci_target_backend_interface_tb_top
